// *** hdl/timeproc_cfg_map.svh ***
// register offsets, field positions, reset values and divider counts for the config block
`ifndef TIMEPROC_CFG_MAP_SVH
`define TIMEPROC_CFG_MAP_SVH
`define CFG_MODULE_OFFSET   32'h0000_0000
`define CFG_TEST_OFFSET     32'h0030_4002
`define CFG_TEST_INDEX      32'h0030_4002
`define CFG_TEST_ADDR       32'h00C1_0008
`define CFG_LOWER_OFFSET    32'h0000_0004
`define BIT_PRIV_ONLY       8
`define BIT_BASE_PSC        9
`define BIT_ENH_MODE        10
`define BIT_T2_EDGE         11
`define BIT_GATE_SEL        6
`define BIT_EXT_PSC         0
`define CFG_RESET_VALUE     16'h0400
`define LOWER_RESET_VALUE   16'h0000
`define DIV_SLOW            32
`define DIV_FAST            4
`define DIV_GATE            8
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2
`endif

// *** hdl/timeproc_cfg_pkg.sv ***
// types shared by the config block
package timeproc_cfg_pkg;
    typedef struct packed {
        logic       privileged_only_select;
        logic       base_prescale_select;
        logic       enhanced_mode_enable;
        logic       second_timebase_edge_select;
        logic [3:0] irq_arbitration_id;
    } cfg_fields_t;
    typedef struct packed {
        logic       extended_prescale_enable;
        logic       second_timebase_gate_select;
    } lower_fields_t;
    typedef enum logic [1:0] {
        T2_PIN_RISE,
        T2_PIN_FALL,
        T2_GATED_RISE,
        T2_GATED_FALL
    } t2_source_t;
endpackage : timeproc_cfg_pkg

// *** hdl/timeproc_module_config_upper.sv ***
// module configuration register, upper half, with clock selects and AXI4-Lite access
`timescale 1ns/1ps
`include "timeproc_cfg_map.svh"
module timeproc_module_config_upper (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // axi4-lite write
    input  wire logic [31:0]              s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0]              s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // timebase clocking, config field outputs and access flag
    input  wire logic                     second_timebase_pin,
    output logic                          first_timebase_tick,
    output logic                          second_timebase_tick,
    output timeproc_cfg_pkg::t2_source_t  second_timebase_source,
    output timeproc_cfg_pkg::cfg_fields_t cfg_fields,
    output logic                          assignable_access_ok
);
    import timeproc_cfg_pkg::*;

    // ---------------- register bank ----------------
    cfg_fields_t   cfg_reg,   cfg_next;
    lower_fields_t low_reg,   low_next;
    logic          enh_locked_reg, enh_locked_next;
    logic          aw_held_reg, aw_held_next;
    logic          w_held_reg,  w_held_next;
    logic [31:0]   awaddr_reg,  awaddr_next;
    logic          awpriv_reg,  awpriv_next;
    logic [31:0]   wdata_reg,   wdata_next;
    logic [3:0]    wstrb_reg,   wstrb_next;
    logic          bvalid_reg,  bvalid_next;
    logic [1:0]    bresp_reg,   bresp_next;
    logic          rvalid_reg,  rvalid_next;
    logic [1:0]    rresp_reg,   rresp_next;
    logic [31:0]   rdata_reg,   rdata_next;
    logic          acc_ok_reg,  acc_ok_next;
    logic          awready_reg, awready_next;
    logic          wready_reg,  wready_next;
    logic          arready_reg, arready_next;

    logic          aw_take, w_take, do_write, ar_take;
    logic [15:0]   cfg_word, low_word;

    assign aw_take  = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
    assign w_take   = s_axi_wvalid && !w_held_reg && !bvalid_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign ar_take  = s_axi_arvalid && !rvalid_reg;

    always_comb begin
        cfg_word = 16'h0000;
        cfg_word[`BIT_PRIV_ONLY] = cfg_reg.privileged_only_select;
        cfg_word[`BIT_BASE_PSC]  = cfg_reg.base_prescale_select;
        cfg_word[`BIT_ENH_MODE]  = cfg_reg.enhanced_mode_enable;
        cfg_word[`BIT_T2_EDGE]   = cfg_reg.second_timebase_edge_select;
        low_word = 16'h0000;
        low_word[`BIT_EXT_PSC]   = low_reg.extended_prescale_enable;
        low_word[`BIT_GATE_SEL]  = low_reg.second_timebase_gate_select;
    end

    always_comb begin
        cfg_next        = cfg_reg;
        low_next        = low_reg;
        enh_locked_next = enh_locked_reg;
        aw_held_next    = aw_held_reg || aw_take;
        w_held_next     = w_held_reg || w_take;
        awaddr_next     = aw_take ? s_axi_awaddr : awaddr_reg;
        awpriv_next     = aw_take ? s_axi_awprot[0] : awpriv_reg;
        wdata_next      = w_take ? s_axi_wdata : wdata_reg;
        wstrb_next      = w_take ? s_axi_wstrb : wstrb_reg;
        bvalid_next     = bvalid_reg && !s_axi_bready;
        bresp_next      = bresp_reg;
        rvalid_next     = rvalid_reg && !s_axi_rready;
        rresp_next      = rresp_reg;
        rdata_next      = rdata_reg;
        acc_ok_next     = !cfg_reg.privileged_only_select || awpriv_reg;
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = `AXI_RESP_OKAY;
            if (awaddr_reg == `CFG_MODULE_OFFSET) begin
                if (wstrb_reg[1]) begin
                    cfg_next.privileged_only_select      = wdata_reg[`BIT_PRIV_ONLY];
                    cfg_next.base_prescale_select        = wdata_reg[`BIT_BASE_PSC];
                    cfg_next.second_timebase_edge_select = wdata_reg[`BIT_T2_EDGE];
                    if (!enh_locked_reg) begin
                        cfg_next.enhanced_mode_enable = wdata_reg[`BIT_ENH_MODE];
                        enh_locked_next = 1'b1;
                    end
                end
            end else if (awaddr_reg == `CFG_LOWER_OFFSET) begin
                if (wstrb_reg[0]) begin
                    low_next.extended_prescale_enable    = wdata_reg[`BIT_EXT_PSC];
                    low_next.second_timebase_gate_select = wdata_reg[`BIT_GATE_SEL];
                end
            end else if (awaddr_reg == `CFG_TEST_ADDR) begin
                bresp_next = `AXI_RESP_OKAY;
            end else begin
                bresp_next = `AXI_RESP_SLVERR;
            end
        end
        if (ar_take) begin
            rvalid_next = 1'b1;
            rresp_next  = `AXI_RESP_OKAY;
            unique case (s_axi_araddr)
                `CFG_MODULE_OFFSET: rdata_next = {16'h0000, cfg_word};
                `CFG_LOWER_OFFSET:  rdata_next = {16'h0000, low_word};
                `CFG_TEST_ADDR:     rdata_next = 32'h0000_0000;
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = `AXI_RESP_SLVERR;
                end
            endcase
        end
        // ready outputs are registered from the next held and valid state, high only while neither is set
        awready_next = !aw_held_next && !bvalid_next;
        wready_next  = !w_held_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg        <= '{1'b0, 1'b0, 1'b1, 1'b0, 4'h0};
            low_reg        <= '{1'b0, 1'b0};
            enh_locked_reg <= 1'b0;
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            awaddr_reg     <= 32'h0000_0000;
            awpriv_reg     <= 1'b0;
            wdata_reg      <= 32'h0000_0000;
            wstrb_reg      <= 4'h0;
            bvalid_reg     <= 1'b0;
            bresp_reg      <= 2'h0;
            rvalid_reg     <= 1'b0;
            rresp_reg      <= 2'h0;
            rdata_reg      <= 32'h0000_0000;
            acc_ok_reg     <= 1'b1;
            awready_reg    <= 1'b1;
            wready_reg     <= 1'b1;
            arready_reg    <= 1'b1;
        end else begin
            cfg_reg        <= cfg_next;
            low_reg        <= low_next;
            enh_locked_reg <= enh_locked_next;
            aw_held_reg    <= aw_held_next;
            w_held_reg     <= w_held_next;
            awaddr_reg     <= awaddr_next;
            awpriv_reg     <= awpriv_next;
            wdata_reg      <= wdata_next;
            wstrb_reg      <= wstrb_next;
            bvalid_reg     <= bvalid_next;
            bresp_reg      <= bresp_next;
            rvalid_reg     <= rvalid_next;
            rresp_reg      <= rresp_next;
            rdata_reg      <= rdata_next;
            acc_ok_reg     <= acc_ok_next;
            awready_reg    <= awready_next;
            wready_reg     <= wready_next;
            arready_reg    <= arready_next;
        end
    end

    assign s_axi_awready        = awready_reg;
    assign s_axi_wready         = wready_reg;
    assign s_axi_bvalid         = bvalid_reg;
    assign s_axi_bresp          = bresp_reg;
    assign s_axi_arready        = arready_reg;
    assign s_axi_rvalid         = rvalid_reg;
    assign s_axi_rresp          = rresp_reg;
    assign s_axi_rdata          = rdata_reg;
    assign cfg_fields           = cfg_reg;
    assign assignable_access_ok = acc_ok_reg;

    // ---------------- timebase clocking ----------------
    logic [4:0]  psc_cnt_reg,  psc_cnt_next;
    logic [2:0]  divide_by_eight_clock_cnt_reg, divide_by_eight_clock_cnt_next;
    logic        pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic        t1_tick_reg, t1_tick_next;
    logic        t2_tick_reg, t2_tick_next;
    t2_source_t  t2_src_reg,  t2_src_next;
    logic [4:0]  psc_last;
    logic        pin_edge;

    always_comb begin
        // slow divider runs unless base_prescale_select picks the fast divide while extended prescale is off
        if (low_reg.extended_prescale_enable) begin
            psc_last = 5'(`DIV_SLOW - 1);
        end else if (cfg_reg.base_prescale_select) begin
            psc_last = 5'(`DIV_FAST - 1);
        end else begin
            psc_last = 5'(`DIV_SLOW - 1);
        end
        psc_cnt_next  = (psc_cnt_reg >= psc_last) ? 5'h00 : psc_cnt_reg + 5'h01;
        t1_tick_next  = (psc_cnt_reg >= psc_last);
        divide_by_eight_clock_cnt_next = divide_by_eight_clock_cnt_reg + 3'h1;
        t2_src_next   = t2_source_t'({low_reg.second_timebase_gate_select,
                                      cfg_reg.second_timebase_edge_select});
        pin_edge = cfg_reg.second_timebase_edge_select ? (pin_s3_reg && !pin_s2_reg)
                                                       : (!pin_s3_reg && pin_s2_reg);
        unique case (t2_src_reg)
            T2_PIN_RISE, T2_PIN_FALL:     t2_tick_next = pin_edge;
            T2_GATED_RISE, T2_GATED_FALL: t2_tick_next = pin_s2_reg
                && (divide_by_eight_clock_cnt_reg == 3'(`DIV_GATE - 1));
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psc_cnt_reg  <= 5'h00;
            divide_by_eight_clock_cnt_reg <= 3'h0;
            pin_s1_reg   <= 1'b0;
            pin_s2_reg   <= 1'b0;
            pin_s3_reg   <= 1'b0;
            t1_tick_reg  <= 1'b0;
            t2_tick_reg  <= 1'b0;
            t2_src_reg   <= T2_PIN_RISE;
        end else begin
            psc_cnt_reg  <= psc_cnt_next;
            divide_by_eight_clock_cnt_reg <= divide_by_eight_clock_cnt_next;
            pin_s1_reg   <= second_timebase_pin;
            pin_s2_reg   <= pin_s1_reg;
            pin_s3_reg   <= pin_s2_reg;
            t1_tick_reg  <= t1_tick_next;
            t2_tick_reg  <= t2_tick_next;
            t2_src_reg   <= t2_src_next;
        end
    end

    assign first_timebase_tick    = t1_tick_reg;
    assign second_timebase_tick   = t2_tick_reg;
    assign second_timebase_source = t2_src_reg;

    // ---------------- checks ----------------
    sequence s_enh_write(logic v);
        do_write && awaddr_reg == `CFG_MODULE_OFFSET && wstrb_reg[1]
            && wdata_reg[`BIT_ENH_MODE] == v;
    endsequence

    property p_enh_reset;
        @(posedge aclk) !aresetn |=> cfg_reg.enhanced_mode_enable;
    endproperty
    a_enh_reset: assert property (p_enh_reset) else $error("enhanced mode not 1 after reset");

    property p_enh_first;
        @(posedge aclk) disable iff (!aresetn)
            (!enh_locked_reg and s_enh_write(1'b0)) |=> !cfg_reg.enhanced_mode_enable;
    endproperty
    a_enh_first: assert property (p_enh_first) else $error("first write to mode bit lost");

    property p_enh_locked;
        @(posedge aclk) disable iff (!aresetn)
            enh_locked_reg |=> $stable(cfg_reg.enhanced_mode_enable);
    endproperty
    a_enh_locked: assert property (p_enh_locked) else $error("mode bit changed after lock");

    // only the divide in force at the fourth cycle decides the next tick
    sequence s_t1_fast_window;
        $rose(t1_tick_reg) ##3 (!low_reg.extended_prescale_enable
                                && cfg_reg.base_prescale_select);
    endsequence

    property p_t1_fast;
        @(posedge aclk) disable iff (!aresetn) s_t1_fast_window |=> t1_tick_reg;
    endproperty
    a_t1_fast: assert property (p_t1_fast) else $error("fast prescale not /4");

    property p_t1_ext;
        @(posedge aclk) disable iff (!aresetn)
            ($rose(t1_tick_reg) ##3 low_reg.extended_prescale_enable) |=> !t1_tick_reg;
    endproperty
    a_t1_ext: assert property (p_t1_ext) else $error("base select acted in extended mode");

    property p_priv;
        @(posedge aclk) disable iff (!aresetn)
            ##1 (cfg_reg.privileged_only_select && !awpriv_reg && $stable(cfg_reg)
                 && $stable(awpriv_reg)) |=> !assignable_access_ok;
    endproperty
    a_priv: assert property (p_priv) else $error("user access allowed in privileged mode");

    property p_src;
        @(posedge aclk) disable iff (!aresetn)
            1'b1 |=> t2_src_reg[1] == $past(low_reg.second_timebase_gate_select)
                && t2_src_reg[0] == $past(cfg_reg.second_timebase_edge_select);
    endproperty
    a_src: assert property (p_src) else $error("second timebase source mismatch");

    property p_gate_pin;
        @(posedge aclk) disable iff (!aresetn)
            (t2_src_reg[1] && !pin_s2_reg) |=> !t2_tick_reg;
    endproperty
    a_gate_pin: assert property (p_gate_pin) else $error("gated clock ticked with pin low");

    property p_rsvd;
        @(posedge aclk) disable iff (!aresetn)
            (ar_take && s_axi_araddr == `CFG_MODULE_OFFSET) |=> s_axi_rdata[15:12] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

    property p_test;
        @(posedge aclk) disable iff (!aresetn)
            (ar_take && s_axi_araddr == `CFG_TEST_ADDR) |=> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_test: assert property (p_test) else $error("test register read nonzero");
endmodule : timeproc_module_config_upper

// *** sim/tb_top.sv ***
// self-checking bench for the upper module configuration register block
`timescale 1ns/1ps
`include "timeproc_cfg_map.svh"
module tb_top;
    import timeproc_cfg_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, second_timebase_pin, first_timebase_tick, second_timebase_tick;
    logic        assignable_access_ok;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd, d;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb, wr_strb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    t2_source_t  second_timebase_source;
    cfg_fields_t cfg_fields;
    int          n_mismatch, num_checks, seed, t2_count, c0;

    timeproc_module_config_upper timeproc_module_config_upper_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .second_timebase_pin, .first_timebase_tick, .second_timebase_tick,
        .second_timebase_source, .cfg_fields, .assignable_access_ok);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) if (second_timebase_tick === 1'b1) t2_count <= t2_count + 1;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    // address and data go out together; each is dropped at the edge that takes it
    task automatic axi_write(input logic [31:0] a, input logic [31:0] dd, input logic [2:0] p);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= a;
        s_axi_awprot <= p;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dd;
        s_axi_wstrb <= wr_strb;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) aw_done = 1;
            if (s_axi_wready === 1'b1) w_done = 1;
            if (aw_done) s_axi_awvalid <= 1'b0;
            if (w_done) s_axi_wvalid <= 1'b0;
        end while (!(aw_done && w_done));
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arprot <= 3'h1;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : axi_read

    function automatic logic [31:0] exp_cfg(input logic [31:0] w, input logic enh);
        return {20'h0, w[11], enh, w[9:8], 8'h00};
    endfunction : exp_cfg

    function automatic logic [7:0] exp_fields(input logic [31:0] w, input logic enh);
        return {w[8], w[9], enh, w[11], 4'h0};
    endfunction : exp_fields

    // the first gap after a config change may be partial, so two ticks are skipped
    task automatic tick_gap(input int exp);
        int n;
        n = 0;
        repeat (2) begin
            @(posedge aclk);
            while (first_timebase_tick !== 1'b1) @(posedge aclk);
        end
        do begin
            @(posedge aclk);
            n++;
        end while (first_timebase_tick !== 1'b1);
        check("tick gap", n, exp);
    endtask : tick_gap

    task automatic pin_pulses(input int n, input int hi);
        repeat (n) begin
            second_timebase_pin <= 1'b1;
            repeat (hi) @(posedge aclk);
            second_timebase_pin <= 1'b0;
            repeat (hi) @(posedge aclk);
        end
        repeat (8) @(posedge aclk);
    endtask : pin_pulses

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset

    initial begin
        seed = 80706;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        // responses are always accepted, so bready and rready never toggle between calls
        {s_axi_bready, s_axi_rready} = 2'b11;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wstrb = 4'h0;
        wr_strb = 4'hF;
        second_timebase_pin = 1'b0;
        {n_mismatch, num_checks} = '0;
        do_reset();
        axi_read(`CFG_MODULE_OFFSET);
        check("cfg reset", rd, 32'h0000_0400);
        check("fields reset", cfg_fields, 8'h20);
        axi_read(`CFG_LOWER_OFFSET);
        check("lower reset", rd, 32'h0000_0000);
        axi_write(`CFG_TEST_ADDR, 32'h0000_FFFF, 3'h1);
        check("test wr resp", rsp, `AXI_RESP_OKAY);
        axi_read(`CFG_TEST_ADDR);
        check("test reg", rd, 32'h0);
        check("test rd resp", rsp, `AXI_RESP_OKAY);
        axi_write(32'h0000_0100, 32'h0000_FFFF, 3'h1);
        check("unmapped wr resp", rsp, `AXI_RESP_SLVERR);
        axi_read(32'h0000_0100);
        check("unmapped resp", rsp, `AXI_RESP_SLVERR);
        // reserved nibble written as ones, enhanced mode cleared to legacy
        axi_write(`CFG_MODULE_OFFSET, 32'h0000_F300, 3'h1);
        axi_read(`CFG_MODULE_OFFSET);
        check("cfg legacy", rd, 32'h0000_0300);
        axi_write(`CFG_MODULE_OFFSET, 32'h0000_0400, 3'h1);
        axi_read(`CFG_MODULE_OFFSET);
        check("cfg relock", rd, 32'h0000_0000);
        // without byte lane 1 the config half must ignore the write
        wr_strb = 4'h1;
        axi_write(`CFG_MODULE_OFFSET, 32'h0000_0B00, 3'h1);
        wr_strb = 4'hF;
        axi_read(`CFG_MODULE_OFFSET);
        check("cfg lane", rd, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            axi_write(i[0] ? `CFG_LOWER_OFFSET : `CFG_MODULE_OFFSET, d, 3'h1);
            axi_read(i[0] ? `CFG_LOWER_OFFSET : `CFG_MODULE_OFFSET);
            check("rand rd", rd, i[0] ? (d & 32'h41) : exp_cfg(d, 1'b0));
            if (!i[0]) check("rand fields", cfg_fields, exp_fields(d, 1'b0));
        end
        // privilege gate: a user write is flagged while privileged only is set
        axi_write(`CFG_MODULE_OFFSET, 32'h0000_0100, 3'h1);
        check("ok super", assignable_access_ok, 1'b1);
        axi_write(`CFG_LOWER_OFFSET, 32'h0, 3'h0);
        check("ok user", assignable_access_ok, 1'b0);
        axi_write(`CFG_MODULE_OFFSET, 32'h0000_0000, 3'h1);
        axi_write(`CFG_LOWER_OFFSET, 32'h0, 3'h0);
        check("ok open", assignable_access_ok, 1'b1);
        tick_gap(`DIV_SLOW);
        axi_write(`CFG_LOWER_OFFSET, 32'h1, 3'h1);
        axi_write(`CFG_MODULE_OFFSET, 32'h0000_0200, 3'h1);
        tick_gap(`DIV_SLOW);
        for (int k = 0; k < 4; k++) begin
            axi_write(`CFG_LOWER_OFFSET, k[1] ? 32'h40 : 32'h0, 3'h1);
            axi_write(`CFG_MODULE_OFFSET, k[0] ? 32'h0000_0800 : 32'h0, 3'h1);
            repeat (4) @(posedge aclk);
            check("t2 source", second_timebase_source, k[1:0]);
            c0 = t2_count;
            pin_pulses(k[1] ? 1 : 4, k[1] ? 64 : 5);
            if (k[1]) check("t2 gated", (t2_count - c0 >= 7) && (t2_count - c0 <= 9), 1);
            else check("t2 edges", t2_count - c0, 4);
        end
        // second reset: the write-once latch opens again
        do_reset();
        axi_write(`CFG_MODULE_OFFSET, 32'h0000_0600, 3'h1);
        axi_write(`CFG_MODULE_OFFSET, 32'h0000_0200, 3'h1);
        axi_read(`CFG_MODULE_OFFSET);
        check("cfg reset2", rd, 32'h0000_0600);
        tick_gap(`DIV_FAST);
        report_and_stop();
    end

    initial begin
        #(8 * 40000);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_top
